//--- logic/mdu_pkg.sv
// package of offsets, fields, reset values and timing counts for the mul/div unit
// assumes an apb slave with 32-bit data, one register per aligned word
package mdu_pkg;
    // ****************************************
    // register indices and byte addresses
    // ****************************************
    localparam logic [15:0] IDX_OPERAND_RESULT = 16'hff62;
    localparam logic [15:0] IDX_MULDIV_CONTROL = 16'hff68;
    localparam logic [15:0] IDX_SECOND_OPERAND = 16'hff6a;
    localparam logic [15:0] IDX_REMAINDER      = 16'hff6c;
    localparam logic [17:0] ADDR_OPERAND_RESULT = {IDX_OPERAND_RESULT, 2'b00};
    localparam logic [17:0] ADDR_MULDIV_CONTROL = {IDX_MULDIV_CONTROL, 2'b00};
    localparam logic [17:0] ADDR_SECOND_OPERAND = {IDX_SECOND_OPERAND, 2'b00};
    localparam logic [17:0] ADDR_REMAINDER      = {IDX_REMAINDER, 2'b00};
    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int          CTRL_RUN_POS   = 7;
    localparam int          CTRL_MODE_POS  = 0;
    localparam logic [7:0]  CTRL_RESET     = 8'h00;
    localparam logic [7:0]  CTRL_MUL_START = 8'h81;
    localparam logic [31:0] OPRES_RESET    = 32'h0000_0000;
    localparam logic [15:0] SECOND_RESET   = 16'h0000;
    localparam logic [15:0] REM_RESET      = 16'h0000;
    // ****************************************
    // timing counts in internal clocks
    // ****************************************
    localparam int MUL_CYCLES = 16;
    localparam int DIV_CYCLES = 32;
    typedef enum logic [1:0] {
        MDU_IDLE = 2'b00,
        MDU_RUN  = 2'b01,
        MDU_DONE = 2'b10
    } mdu_state_t;
endpackage

//--- logic/mdu_step.sv
// one-bit arithmetic step of the mul/div unit
// assumes the caller holds the accumulator state between steps
`timescale 1ns/100ps
module mdu_step
    import mdu_pkg::*;
(
    input  wire logic        mode_mul,
    input  wire logic [31:0] acc_in,
    input  wire logic [15:0] rem_in,
    input  wire logic [15:0] operand_b,
    input  wire logic [15:0] mcand,
    output logic      [31:0] acc_out,
    output logic      [15:0] rem_out
);
    logic [16:0] part;
    logic [16:0] trial;
    always_comb begin
        part    = 17'h00000;
        trial   = 17'h00000;
        acc_out = acc_in;
        rem_out = rem_in;
        if (mode_mul) begin
            // shift-and-add: acc = {partial hi, multiplier lo}
            part = {1'b0, acc_in[31:16]} + (acc_in[0] ? {1'b0, mcand} : 17'h00000);
            acc_out = {part, acc_in[15:1]};
            rem_out = rem_in;
        end else begin
            // restoring shift-and-subtract, quotient bits shift into acc
            trial = {rem_in, acc_in[31]} - {1'b0, operand_b};
            if (trial[16] && !rem_in[15]) begin
                rem_out = {rem_in[14:0], acc_in[31]};
                acc_out = {acc_in[30:0], 1'b0};
            end else begin
                rem_out = trial[15:0];
                acc_out = {acc_in[30:0], 1'b1};
            end
        end
    end
endmodule

//--- logic/mdu_top.sv
// apb-mapped unsigned multiplier/divider of an 8-bit microcontroller core
// assumes synchronous apb master on pclk, active-low asynchronous presetn
// Function
// - 16x16 multiply and 32/16 divide
// - 32-bit operand/result register, two halves
// - multiply start clears high half
// - operand and remainder read intermediate during run
// - product/quotient to 31:0, remainder 15:0
// - 16-bit second operand, byte writable
// - reset clears control and operand registers
// - bit7 run, bit0 mode, others zero
// - run bit starts, clears itself when done
// - clearing run aborts; completion still wins
// - multiply finishes after 16 clocks
// - divide finishes after 32 clocks
// - store result, clear run, then irq
// - operand register loads running result each clock
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module mdu_top
    import mdu_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   op_done_irq
);
    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  lanes);
        merge16 = {lanes[1] ? new_v[15:8] : old_v[15:8],
                   lanes[0] ? new_v[7:0]  : old_v[7:0]};
    endfunction

    typedef enum logic [2:0] {
        MDU_SEL_NONE   = 3'b000,
        MDU_SEL_OPRES  = 3'b001,
        MDU_SEL_CTRL   = 3'b010,
        MDU_SEL_SECOND = 3'b011,
        MDU_SEL_REM    = 3'b100
    } mdu_sel_t;

    // address to register select, shared by write decode and read mux
    function automatic mdu_sel_t decode_addr(input logic [ADDR_W-1:0] a);
        decode_addr = MDU_SEL_NONE;
        if (a == ADDR_OPERAND_RESULT[ADDR_W-1:0]) begin
            decode_addr = MDU_SEL_OPRES;
        end else if (a == ADDR_MULDIV_CONTROL[ADDR_W-1:0]) begin
            decode_addr = MDU_SEL_CTRL;
        end else if (a == ADDR_SECOND_OPERAND[ADDR_W-1:0]) begin
            decode_addr = MDU_SEL_SECOND;
        end else if (a == ADDR_REMAINDER[ADDR_W-1:0]) begin
            decode_addr = MDU_SEL_REM;
        end
    endfunction

    // ****************************************
    // state
    // ****************************************
    mdu_state_t  state;
    logic [31:0] operand_result;
    logic [15:0] second_operand;
    logic [15:0] remainder_reg;
    logic [15:0] mcand;
    logic        run_bit;
    logic        mode_select_bit;
    logic [5:0]  step_cnt;
    logic [31:0] next_acc;
    logic [15:0] next_rem;
    logic        last_step;

    // ****************************************
    // apb decode
    // ****************************************
    mdu_sel_t    sel;
    logic        access;
    logic        wr;
    logic        hit_opres;
    logic        hit_ctrl;
    logic        hit_second;
    logic        hit_rem;
    logic        hit_any;
    logic        start_wr;
    logic        stop_wr;

    assign access = psel && penable && clk_en;
    assign wr     = access && pwrite;
    assign pready = 1'b1;

    assign sel        = decode_addr(paddr);
    assign hit_opres  = (sel == MDU_SEL_OPRES);
    assign hit_ctrl   = (sel == MDU_SEL_CTRL);
    assign hit_second = (sel == MDU_SEL_SECOND);
    assign hit_rem    = (sel == MDU_SEL_REM);

    assign hit_any  = hit_opres || hit_ctrl || hit_second || hit_rem;
    assign pslverr  = psel && penable && !hit_any;
    assign start_wr = wr && hit_ctrl && pstrb[0] && pwdata[CTRL_RUN_POS] && !run_bit;
    assign stop_wr  = wr && hit_ctrl && pstrb[0] && !pwdata[CTRL_RUN_POS];
    assign last_step = (state == MDU_RUN) &&
                       (step_cnt == (mode_select_bit ? 6'(MUL_CYCLES - 1)
                                                     : 6'(DIV_CYCLES - 1)));

    // ****************************************
    // arithmetic step
    // ****************************************
    mdu_step u_step (
        .mode_mul  (mode_select_bit),
        .acc_in    (operand_result),
        .rem_in    (remainder_reg),
        .operand_b (second_operand),
        .mcand     (mcand),
        .acc_out   (next_acc),
        .rem_out   (next_rem)
    );

    // ****************************************
    // sequencer
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state    <= MDU_IDLE;
            step_cnt <= 6'h00;
        end else if (clk_en) begin
            case (state)
                MDU_IDLE: begin
                    step_cnt <= 6'h00;
                    if (start_wr) begin
                        state <= MDU_RUN;
                    end
                end
                MDU_RUN: begin
                    step_cnt <= step_cnt + 6'h01;
                    if (last_step) begin
                        state <= MDU_DONE;
                    end else if (stop_wr) begin
                        state <= MDU_IDLE;
                    end
                end
                MDU_DONE: begin
                    // start written in the done cycle is kept
                    step_cnt <= 6'h00;
                    if (start_wr) begin
                        state <= MDU_RUN;
                    end else begin
                        state <= MDU_IDLE;
                    end
                end
                default: begin
                    state <= MDU_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // control register
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_bit         <= CTRL_RESET[CTRL_RUN_POS];
            mode_select_bit <= CTRL_RESET[CTRL_MODE_POS];
        end else if (clk_en) begin
            if (last_step) begin
                run_bit <= 1'b0;
            end else if (wr && hit_ctrl && pstrb[0]) begin
                run_bit <= pwdata[CTRL_RUN_POS];
            end
            if (wr && hit_ctrl && pstrb[0] && state != MDU_RUN) begin
                mode_select_bit <= pwdata[CTRL_MODE_POS];
            end
        end
    end

    // ****************************************
    // operand/result and remainder
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remainder_reg <= REM_RESET;
        end else if (clk_en) begin
            if (start_wr) begin
                remainder_reg <= REM_RESET;
            end else if (state == MDU_RUN) begin
                remainder_reg <= next_rem;
            end
        end
    end

    // multiplicand held from start
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mcand <= SECOND_RESET;
        end else if (clk_en && start_wr) begin
            mcand <= second_operand;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operand_result <= OPRES_RESET;
        end else if (clk_en) begin
            if (start_wr) begin
                if (pwdata[CTRL_MODE_POS]) begin
                    operand_result[31:16] <= 16'h0000;
                end
            end else if (state == MDU_RUN) begin
                operand_result <= next_acc;
            end else if (wr && hit_opres) begin
                operand_result[15:0]  <= merge16(operand_result[15:0], pwdata[15:0],
                                                 pstrb[1:0]);
                operand_result[31:16] <= merge16(operand_result[31:16], pwdata[31:16],
                                                 pstrb[3:2]);
            end
        end
    end

    // ****************************************
    // second operand
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            second_operand <= SECOND_RESET;
        end else if (clk_en && wr && hit_second) begin
            second_operand <= merge16(second_operand, pwdata[15:0], pstrb[1:0]);
        end
    end

    // ****************************************
    // done pulse
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_done_irq <= 1'b0;
        end else if (clk_en) begin
            op_done_irq <= (state == MDU_DONE);
        end
    end

    // ****************************************
    // read data
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (clk_en && psel && !penable && !pwrite) begin
            if (sel == MDU_SEL_OPRES) begin
                prdata <= operand_result;
            end else if (sel == MDU_SEL_CTRL) begin
                prdata <= {24'h000000, run_bit, 6'h00, mode_select_bit};
            end else if (sel == MDU_SEL_SECOND) begin
                prdata <= {16'h0000, second_operand};
            end else if (sel == MDU_SEL_REM) begin
                prdata <= {16'h0000, remainder_reg};
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end
endmodule

//--- tb/mdu_assertions.sv
// checker for the mul/div unit, watching the top module ports only
// assumes pclk clock and presetn asynchronous active-low reset
`timescale 1ns/100ps
module mdu_checker
    import mdu_pkg::*;
#(
    parameter int ADDR_W = 18
)
(
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              clk_en,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              op_done_irq
);
    // ****************************************
    // run tracker
    // ****************************************
    logic [5:0] left;
    wire acc      = psel && penable;
    wire ctl_sel  = paddr == ADDR_MULDIV_CONTROL;
    wire ctl_wr   = acc && pwrite && clk_en && pstrb[0] && ctl_sel;
    wire rd_setup = psel && !penable && !pwrite && clk_en;
    wire mapped   = paddr == ADDR_OPERAND_RESULT || ctl_sel
                    || paddr == ADDR_SECOND_OPERAND || paddr == ADDR_REMAINDER;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left <= 6'd0;
        end else if (clk_en) begin
            if (ctl_wr && pwdata[7] && left == 6'd0) begin
                left <= pwdata[0] ? 6'd16 : 6'd32;
            end else if (ctl_wr && !pwdata[7] && left > 6'd1) begin
                left <= 6'd0;
            end else if (left != 6'd0) begin
                left <= left - 6'd1;
            end
        end
    end
    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_map: assert property (acc |-> pslverr == !mapped) else $error("bad pslverr");
    a_err_rdata: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    a_ctrl_read: assert property (acc && !pwrite && ctl_sel |-> prdata[31:8] == 24'h0
        && prdata[6:1] == 6'h0 && prdata[7] == ($past(left) != 6'd0))
        else $error("bad control read");
    a_done_pulse: assert property (left == 6'd1 && clk_en
        |=> !op_done_irq ##1 op_done_irq ##1 !op_done_irq) else $error("done pulse late");
    a_irq_cause: assert property ($rose(op_done_irq) |-> $past(left, 2) == 6'd1)
        else $error("irq without completion");
    a_irq_single: assert property (op_done_irq |=> !op_done_irq)
        else $error("irq too long");
    a_rd_hold: assert property (!$past(rd_setup) |-> $stable(prdata))
        else $error("read data moved");
    c_mul: cover property (ctl_wr && pwdata[7:0] == CTRL_MUL_START);
    c_div: cover property (ctl_wr && pwdata[7:0] == 8'h80);
    c_irq: cover property (op_done_irq);
endmodule

bind mdu_top mdu_checker #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .op_done_irq(op_done_irq));

//--- tb/mdu_top_bench.sv
// self-checking bench for the mul/div unit over apb
// assumes the checker is bound to the top module
`timescale 1ns/100ps
module mdu_top_bench
    import mdu_pkg::*;
();
    typedef struct packed {
        logic [7:0]  ctl;
        logic [31:0] a;
        logic [15:0] b;
        logic [31:0] q;
        logic [15:0] r;
    } mdu_row_t;
    localparam mdu_row_t ROWS [6] = '{
        '{8'h81, 32'h1234_ffff, 16'hffff, 32'hfffe_0001, 16'h0},
        '{8'h81, 32'h0000_00da, 16'h0093, 32'h0000_7d2e, 16'h0},
        '{8'h80, 32'hdcba_2586, 16'h0018, 32'h0932_6c3a, 16'h0016},
        '{8'h80, 32'hffff_ffff, 16'h0001, 32'hffff_ffff, 16'h0},
        '{8'h80, 32'h1234_5678, 16'h0100, 32'h0012_3456, 16'h0078},
        '{8'h80, 32'h0000_0005, 16'h0007, 32'h0000_0000, 16'h0005}};
    localparam logic [17:0] ADRS [4] = '{ADDR_OPERAND_RESULT, ADDR_MULDIV_CONTROL,
        ADDR_SECOND_OPERAND, ADDR_REMAINDER};
    logic        pclk    = 1'b0;
    logic        presetn = 1'b0;
    logic        clk_en  = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [17:0] paddr   = 18'h0;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'h0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, op_done_irq, err, seen;
    int          n_errors = 0;
    int          tests_run = 0;
    always #25 pclk = ~pclk;
    mdu_top DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .op_done_irq(op_done_irq));
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t word %h not %h", $time, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t flag %b not %b", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_irq(output logic hit);
        hit = 1'b0;
        for (int i = 0; i < 40 && !hit; i++) begin
            @(posedge pclk);
            hit = op_done_irq === 1'b1;
        end
    endtask
    task automatic run_op(input mdu_row_t t);
        apb(1'b1, ADDR_OPERAND_RESULT, t.a, 4'hf);
        apb(1'b1, ADDR_SECOND_OPERAND, {16'h0, t.b}, 4'h3);
        apb(1'b1, ADDR_MULDIV_CONTROL, {24'h0, t.ctl}, 4'h1);
        wait_irq(seen);
        chk_flag(seen, 1'b1);
        apb(1'b0, ADDR_OPERAND_RESULT, 32'h0, 4'h0);
        chk_word(rd, t.q);
        apb(1'b0, ADDR_REMAINDER, 32'h0, 4'h0);
        if (!t.ctl[0]) chk_word(rd, {16'h0, t.r});
        apb(1'b0, ADDR_MULDIV_CONTROL, 32'h0, 4'h0);
        chk_word(rd, {31'h0, t.ctl[0]});
    endtask
    task automatic complete_run();
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial begin
        repeat (20000) @(posedge pclk);
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 6; i++) run_op(ROWS[i]);
        apb(1'b1, ADDR_MULDIV_CONTROL, 32'h80, 4'h1);
        apb(1'b0, ADDR_MULDIV_CONTROL, 32'h0, 4'h0);
        chk_word(rd, 32'h80);
        apb(1'b1, ADDR_MULDIV_CONTROL, 32'h0, 4'h1);
        wait_irq(seen);
        chk_flag(seen, 1'b0);
        run_op(ROWS[2]);
        // stop lands on the last step edge: completion wins
        apb(1'b1, ADDR_OPERAND_RESULT, ROWS[1].a, 4'hf);
        apb(1'b1, ADDR_SECOND_OPERAND, {16'h0, ROWS[1].b}, 4'h3);
        apb(1'b1, ADDR_MULDIV_CONTROL, 32'h81, 4'h1);
        repeat (MUL_CYCLES - 3) @(posedge pclk);
        apb(1'b1, ADDR_MULDIV_CONTROL, 32'h1, 4'h1);
        wait_irq(seen);
        chk_flag(seen, 1'b1);
        apb(1'b0, ADDR_OPERAND_RESULT, 32'h0, 4'h0);
        chk_word(rd, ROWS[1].q);
        apb(1'b1, ADDR_OPERAND_RESULT, 32'h5555_aaaa, 4'h6);
        apb(1'b0, ADDR_OPERAND_RESULT, 32'h0, 4'h0);
        chk_word(rd, 32'h0055_aa2e);
        apb(1'b1, ADDR_MULDIV_CONTROL, 32'h7e, 4'h1);
        apb(1'b0, ADDR_MULDIV_CONTROL, 32'h0, 4'h0);
        chk_word(rd, 32'h0);
        apb(1'b1, ADDR_SECOND_OPERAND, 32'h0000_abcd, 4'h3);
        apb(1'b1, ADDR_SECOND_OPERAND, 32'h0000_12ff, 4'h2);
        apb(1'b0, ADDR_SECOND_OPERAND, 32'h0, 4'h0);
        chk_word(rd, 32'h0000_12cd);
        chk_flag(err, 1'b0);
        apb(1'b0, 18'h0, 32'h0, 4'h0);
        chk_flag(err, 1'b1);
        chk_word(rd, 32'h0);
        clk_en <= 1'b0;
        apb(1'b1, ADDR_MULDIV_CONTROL, 32'h81, 4'h1);
        clk_en <= 1'b1;
        apb(1'b0, ADDR_MULDIV_CONTROL, 32'h0, 4'h0);
        chk_word(rd, 32'h0);
        apb(1'b0, ADDR_SECOND_OPERAND, 32'h0, 4'h0);
        apb(1'b1, ADDR_MULDIV_CONTROL, 32'h80, 4'h1);
        repeat (3) @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk_word(prdata, 32'h0);
        chk_flag(op_done_irq, 1'b0);
        @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, ADRS[i], 32'h0, 4'h0);
            chk_word(rd, 32'h0);
        end
        complete_run();
    end
endmodule
